// *** core/erc_pkg.sv ***
package erc_pkg;

  localparam int ADDR_W = 16;
  localparam int IDX_W  = 14;

  // register indices; byte address is four times the index
  localparam logic [13:0] IDX_REFRESH_CTRL = 14'h2020;
  localparam logic [13:0] IDX_TCFG    = 14'h2034;
  localparam logic [13:0] IDX_WIN0_LO = 14'h202c;
  localparam logic [13:0] IDX_WIN0_HI = 14'h2fec;
  localparam logic [13:0] IDX_WIN1_LO = 14'h202e;
  localparam logic [13:0] IDX_WIN1_HI = 14'h2fee;
  // aliases repeat every 64 index steps, so the low six bits pick the window
  localparam logic [5:0]  WIN0_SLOT   = 6'h2c;
  localparam logic [5:0]  WIN1_SLOT   = 6'h2e;

  localparam logic [16:0] REFRESH_CTRL_RST = 17'h00001;
  localparam logic [13:0] TCFG_RST    = 14'h0000;

  localparam logic [1:0]  WIDTH_OFF   = 2'h0;
  localparam logic [1:0]  WIDTH_8     = 2'h1;
  localparam logic [1:0]  WIDTH_16    = 2'h2;

  localparam logic [1:0]  MEMTYPE_DRAM  = 2'h2;
  localparam logic [1:0]  MEMTYPE_SDRAM = 2'h3;

  localparam logic [11:0] REF_TERM    = 12'h800;
  localparam logic [2:0]  HOLD_MIN_CODE = 3'h2;
  localparam logic [2:0]  CAS_HOLD_MAX = 3'h4;
  localparam logic [2:0]  CAS_HOLD_SAT = 3'h5;

  typedef enum logic [2:0] {
    PH_IDLE   = 3'b000,
    PH_SETUP  = 3'b001,
    PH_ACCESS = 3'b010,
    PH_HOLD   = 3'b011,
    PH_DONE   = 3'b100
  } erc_phase_e;

  typedef struct packed {
    logic        cas_setup;
    logic [2:0]  cas_hold;
    logic        refresh_en;
    logic [10:0] interval_count;
    logic        valid;
  } erc_refresh_ctrl_s;

  typedef struct packed {
    logic [2:0] acc;
    logic [2:0] coh;
    logic [2:0] rsv;
    logic [2:0] cos;
    logic [1:0] width;
  } erc_tcfg_s;

  typedef struct packed {
    logic refresh_ctrl;
    logic tcfg;
    logic win0;
    logic win1;
  } erc_hit_s;

  typedef struct packed {
    erc_phase_e phase;
    logic [3:0] cnt;
  } erc_step_s;

endpackage

// *** core/erc_addr_decode.sv ***
`timescale 1ns/1ps
module erc_addr_decode import erc_pkg::*; (
  input  wire logic [15:0] paddr,
  output erc_hit_s         hit
);
  logic [13:0] idx;
  logic        aligned;

  always_comb begin
    idx = paddr[15:2];
    aligned = (paddr[1:0] == 2'h0);
    hit.refresh_ctrl = aligned && (idx == IDX_REFRESH_CTRL);
    hit.tcfg   = aligned && (idx == IDX_TCFG);
    hit.win0   = aligned && (idx[5:0] == WIN0_SLOT)
                 && (idx >= IDX_WIN0_LO) && (idx <= IDX_WIN0_HI);
    hit.win1   = aligned && (idx[5:0] == WIN1_SLOT)
                 && (idx >= IDX_WIN1_LO) && (idx <= IDX_WIN1_HI);
  end
endmodule

// *** core/erc_refresh_timer.sv ***
`timescale 1ns/1ps
module erc_refresh_timer import erc_pkg::*; (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [10:0] interval_count,
  input  wire logic        enable,
  output logic             tick
);
  typedef struct packed {
    logic [11:0] cnt;
    logic        tick;
  } erc_tmr_s;

  erc_tmr_s s_r;
  erc_tmr_s s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (!enable) begin
      s_nxt.cnt = {1'b0, interval_count};
    end else if (s_r.cnt == REF_TERM) begin
      s_nxt.cnt = {1'b0, interval_count};
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 12'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;
endmodule

// *** core/erc_ctrl.sv ***
`timescale 1ns/1ps
// Contract
// - window access drives select, address, data
// - window timing comes only from timing register
// - gpio-mode shared pin never drives select
// - window 0 aliases every 256 bytes
// - window 1 aliases, drives select 1
// - validity resets 1, cleared on access
// - refresh period is 2048 minus count plus one
// - enable gives dram or sdram refresh
// - cas hold code 0..4 gives 1..5
// - cas setup bit gives 1 or 2
// - width field: off, 8-bit, 16-bit
// - select setup equals code clocks
// - select hold zero for codes 0,1
// - access zero at 0, else code plus one
module erc_ctrl import erc_pkg::*; (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [15:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sys_mgr_access,
  input  wire logic        port2_bit7_gpio,
  input  wire logic        port3_bit7_gpio,
  input  wire logic [1:0]  bank6_memory_type,
  input  wire logic [1:0]  bank7_memory_type,
  output logic             ext_select_0_n,
  output logic             ext_select_0_oe,
  output logic             ext_select_1_n,
  output logic             ext_select_1_oe,
  output logic      [15:0] ext_addr,
  output logic      [15:0] ext_wdata,
  output logic             ext_data_oe,
  input  wire logic [15:0] ext_rdata,
  output logic             output_enable_n,
  output logic             ext_write_n,
  output logic             bank_access_en,
  output logic             dram_refresh_req,
  output logic             sdram_autorefresh_req,
  output logic      [2:0]  cas_hold_clks,
  output logic      [1:0]  cas_setup_clks
);

  typedef struct packed {
    erc_refresh_ctrl_s refresh_ctrl;
    erc_tcfg_s   tcfg;
    erc_phase_e  phase;
    logic [3:0]  cnt;
    logic        win1;
    logic        wr;
    logic        two_beats;
    logic        hi_byte;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [31:0] prdata;
    logic        dram_req;
    logic        sdram_req;
  } erc_state_s;

  erc_state_s s_r;
  erc_state_s s_nxt;
  erc_hit_s   hit;
  logic       tick;
  logic       setup_ph;
  logic       acc_ph;
  logic       win_hit;
  logic       win_off;
  logic       reg_done;
  logic       cs_on;
  logic       any_dram;
  logic       any_sdram;
  erc_step_s  st;

  erc_addr_decode u_dec (
    .paddr (paddr),
    .hit   (hit)
  );

  erc_refresh_timer u_tmr (
    .pclk    (pclk),
    .presetn (presetn),
    .interval_count (s_r.refresh_ctrl.interval_count),
    .enable         (s_r.refresh_ctrl.refresh_en),
    .tick    (tick)
  );

  // phase that follows p; phases with zero clocks are skipped
  function automatic erc_step_s step_after(erc_phase_e p, erc_tcfg_s c);
    erc_step_s r;
    r.phase = PH_DONE;
    r.cnt = 4'h0;
    if (p == PH_IDLE && c.cos != 3'h0) begin
      r.phase = PH_SETUP;
      r.cnt = {1'b0, c.cos} - 4'h1;
    end else if ((p == PH_IDLE || p == PH_SETUP) && c.acc != 3'h0) begin
      r.phase = PH_ACCESS;
      r.cnt = {1'b0, c.acc};
    end else if (p != PH_HOLD && c.coh >= HOLD_MIN_CODE) begin
      r.phase = PH_HOLD;
      r.cnt = {1'b0, c.coh} - 4'h1;
    end
    return r;
  endfunction

  always_comb begin
    setup_ph = psel && !penable;
    acc_ph   = psel && penable;
    win_hit  = hit.win0 || hit.win1;
    win_off  = (s_r.tcfg.width == WIDTH_OFF) || (s_r.tcfg.width == 2'h3);
    reg_done = acc_ph && !(win_hit && !win_off);
    any_dram = (bank6_memory_type == MEMTYPE_DRAM) || (bank7_memory_type == MEMTYPE_DRAM);
    any_sdram = (bank6_memory_type == MEMTYPE_SDRAM) || (bank7_memory_type == MEMTYPE_SDRAM);
  end

  always_comb begin
    s_nxt = s_r;
    st = '0;
    s_nxt.dram_req = 1'b0;
    s_nxt.sdram_req = 1'b0;

    // register read data is staged in the setup cycle
    if (setup_ph) begin
      if (hit.refresh_ctrl) begin
        s_nxt.prdata = {15'h0000, s_r.refresh_ctrl};
      end else if (hit.tcfg) begin
        s_nxt.prdata = {18'h00000, s_r.tcfg};
      end else begin
        s_nxt.prdata = 32'h00000000;
      end
    end

    if ((reg_done && (hit.refresh_ctrl || hit.tcfg)) || sys_mgr_access) begin
      s_nxt.refresh_ctrl.valid = 1'b0;
    end
    if (reg_done && pwrite && hit.refresh_ctrl) begin
      // a write with bit 0 set wins over the clear
      s_nxt.refresh_ctrl = erc_refresh_ctrl_s'(pwdata[16:0]);
    end
    if (reg_done && pwrite && hit.tcfg) begin
      s_nxt.tcfg = erc_tcfg_s'(pwdata[13:0]);
      s_nxt.tcfg.rsv = 3'h0;
    end

    case (s_r.phase)
      PH_IDLE: begin
        // window access launches an external cycle
        if (acc_ph && win_hit && !win_off) begin
          s_nxt.win1 = hit.win1;
          s_nxt.wr = pwrite;
          s_nxt.two_beats = (s_r.tcfg.width == WIDTH_8);
          s_nxt.hi_byte = 1'b0;
          s_nxt.addr = {2'b00, paddr[15:2]};
          s_nxt.wdata = pwdata[15:0];
          s_nxt.rdata = 16'h0000;
          st = step_after(PH_IDLE, s_r.tcfg);
          s_nxt.phase = st.phase;
          s_nxt.cnt = st.cnt;
        end
      end
      PH_SETUP, PH_ACCESS, PH_HOLD: begin
        if (s_r.phase == PH_ACCESS && !s_r.wr) begin
          if (!s_r.two_beats) begin
            s_nxt.rdata = ext_rdata;
          end else if (s_r.hi_byte) begin
            s_nxt.rdata[15:8] = ext_rdata[7:0];
          end else begin
            s_nxt.rdata[7:0] = ext_rdata[7:0];
          end
        end
        if (s_r.cnt != 4'h0) begin
          s_nxt.cnt = s_r.cnt - 4'h1;
        end else begin
          st = step_after(s_r.phase, s_r.tcfg);
          // 8-bit bus moves the upper byte in a second beat
          if (st.phase == PH_DONE && s_r.two_beats && !s_r.hi_byte) begin
            s_nxt.hi_byte = 1'b1;
            s_nxt.addr = s_r.addr + 16'h0001;
            st = step_after(PH_IDLE, s_r.tcfg);
          end
          s_nxt.phase = st.phase;
          s_nxt.cnt = st.cnt;
        end
      end
      PH_DONE: begin
        s_nxt.phase = PH_IDLE;
      end
      default: begin
        s_nxt.phase = PH_IDLE;
      end
    endcase

    // window read data is final on entry to the answer cycle
    if (s_nxt.phase == PH_DONE && s_r.phase != PH_DONE) begin
      s_nxt.prdata = {16'h0000, s_nxt.rdata};
    end

    // refresh type follows bank memory type
    if (tick && s_r.refresh_ctrl.refresh_en) begin
      s_nxt.dram_req = any_dram;
      s_nxt.sdram_req = any_sdram;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.refresh_ctrl <= erc_refresh_ctrl_s'(REFRESH_CTRL_RST);
      s_r.tcfg <= erc_tcfg_s'(TCFG_RST);
      s_r.phase <= PH_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_comb begin
    cs_on = (s_r.phase == PH_SETUP) || (s_r.phase == PH_ACCESS) || (s_r.phase == PH_HOLD);
    prdata = s_r.prdata;
    // window cycles stall the bus until the answer cycle
    pready = reg_done || (s_r.phase == PH_DONE);
    pslverr = acc_ph && ((win_hit && win_off)
              || !(win_hit || hit.refresh_ctrl || hit.tcfg));
    ext_select_0_oe = !port2_bit7_gpio;
    ext_select_1_oe = !port3_bit7_gpio;
    ext_select_0_n = !(cs_on && !s_r.win1 && !port2_bit7_gpio);
    ext_select_1_n = !(cs_on && s_r.win1 && !port3_bit7_gpio);
    ext_addr = s_r.addr;
    // 8-bit beats use the low lane
    if (s_r.two_beats) begin
      ext_wdata = {8'h00, s_r.hi_byte ? s_r.wdata[15:8] : s_r.wdata[7:0]};
    end else begin
      ext_wdata = s_r.wdata;
    end
    ext_data_oe = cs_on && s_r.wr;
    output_enable_n = !(s_r.phase == PH_ACCESS && !s_r.wr);
    ext_write_n = !(s_r.phase == PH_ACCESS && s_r.wr);
    bank_access_en = s_r.refresh_ctrl.valid;
    dram_refresh_req = s_r.dram_req;
    sdram_autorefresh_req = s_r.sdram_req;
    if (s_r.refresh_ctrl.cas_hold > CAS_HOLD_MAX) begin
      cas_hold_clks = CAS_HOLD_SAT;
    end else begin
      cas_hold_clks = s_r.refresh_ctrl.cas_hold + 3'h1;
    end
    cas_setup_clks = {1'b0, 1'b1} + {1'b0, s_r.refresh_ctrl.cas_setup};
  end

endmodule

// *** testbench/erc_ctrl_monitor.sv ***
`timescale 1ns/1ps
module erc_ctrl_monitor import erc_pkg::*; (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [15:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sys_mgr_access,
  input wire logic        port2_bit7_gpio,
  input wire logic        port3_bit7_gpio,
  input wire logic        ext_select_0_n,
  input wire logic        ext_select_0_oe,
  input wire logic        ext_select_1_n,
  input wire logic        ext_select_1_oe,
  input wire logic        output_enable_n,
  input wire logic        ext_write_n,
  input wire logic        ext_data_oe,
  input wire logic        bank_access_en,
  input wire logic        dram_refresh_req,
  input wire logic [2:0]  cas_hold_clks,
  input wire logic [1:0]  cas_setup_clks
);
  logic       refresh_wr;
  logic [2:0] ch_w;
  logic       cs_w;
  logic       v_w;
  assign refresh_wr = psel && penable && pready && pwrite && (paddr == 16'h8080);
  assign ch_w = pwdata[15:13];
  assign cs_w = pwdata[16];
  assign v_w = pwdata[0];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_gpio_sel_off: assert property (
    ext_select_0_oe == !port2_bit7_gpio && ext_select_1_oe == !port3_bit7_gpio
    && (!port2_bit7_gpio || ext_select_0_n) && (!port3_bit7_gpio || ext_select_1_n))
    else $error("select driven on gpio pin");
  a_one_select: assert property (ext_select_0_n || ext_select_1_n)
    else $error("both selects low");
  a_read_in_sel: assert property (
    !output_enable_n |-> (!ext_select_0_n || !ext_select_1_n))
    else $error("read strobe without select");
  a_write_drive: assert property (!ext_write_n |-> ext_data_oe && output_enable_n)
    else $error("write strobe without data drive");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_valid_clear: assert property (sys_mgr_access && !refresh_wr |=> !bank_access_en)
    else $error("validity not cleared");
  a_valid_load: assert property (refresh_wr |=> bank_access_en == $past(v_w))
    else $error("validity not loaded");
  a_cas_hold: assert property (
    refresh_wr && ch_w <= 3'h4 |=> cas_hold_clks == $past(ch_w) + 3'h1)
    else $error("cas hold mapping wrong");
  a_cas_setup: assert property (
    refresh_wr |=> cas_setup_clks == ($past(cs_w) ? 2'h2 : 2'h1))
    else $error("cas setup mapping wrong");
  a_pulse_single: assert property (dram_refresh_req |=> !dram_refresh_req)
    else $error("refresh pulse too long");
endmodule

// *** testbench/erc_ext_dev.sv ***
`timescale 1ns/1ps
module erc_ext_dev (
  input  wire logic        clk,
  input  wire logic        sel0_n,
  input  wire logic        sel1_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [15:0] addr,
  input  wire logic [15:0] wdata,
  output logic      [15:0] rdata
);
  logic [15:0] mem [0:4095];
  logic [1:0]  wsel = 2'b00;
  logic [15:0] last = 16'h0000;
  wire         sel = !sel0_n || !sel1_n;
  // answers only when selected
  // released bus toggles so a stale value never passes
  assign rdata = (sel && !oe_n) ? mem[addr[11:0]] : ~last;
  always @(posedge clk) begin
    if (sel && !we_n) begin
      mem[addr[11:0]] <= wdata;
      wsel <= {!sel1_n, !sel0_n};
    end
    last <= rdata;
  end
endmodule

// *** testbench/erc_ctrl_tb_top.sv ***
`timescale 1ns/1ps
module erc_ctrl_tb_top import erc_pkg::*; ;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        sys_mgr_access = 0, port2_bit7_gpio = 0, port3_bit7_gpio = 0;
  logic [15:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [1:0]  bank6_memory_type = 0, bank7_memory_type = 0, cas_setup_clks;
  logic        pready, pslverr, er, ext_data_oe, output_enable_n, ext_write_n;
  logic        ext_select_0_n, ext_select_0_oe, ext_select_1_n, ext_select_1_oe;
  logic        bank_access_en, dram_refresh_req, sdram_autorefresh_req;
  logic [15:0] ext_addr, ext_wdata, ext_rdata;
  logic [2:0]  cas_hold_clks;
  logic [31:0] cfg [3] = '{32'ha06, 32'h102, 32'h1009};
  int          wt [3] = '{6, 1, 11};
  logic [15:0] mv [3] = '{16'h5a3c, 16'h5a3c, 16'h003e};
  logic [31:0] rv [3] = '{32'h00005a3c, 32'h00000000, 32'h00005a3e};
  int          err_total = 0, checks_done = 0, nw;
  erc_ctrl dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .sys_mgr_access, .port2_bit7_gpio, .port3_bit7_gpio,
    .bank6_memory_type, .bank7_memory_type, .ext_select_0_n, .ext_select_0_oe,
    .ext_select_1_n, .ext_select_1_oe, .ext_addr, .ext_wdata, .ext_data_oe, .ext_rdata,
    .output_enable_n, .ext_write_n, .bank_access_en, .dram_refresh_req,
    .sdram_autorefresh_req, .cas_hold_clks, .cas_setup_clks);
  erc_ext_dev u_dev (.clk(pclk), .sel0_n(ext_select_0_n), .sel1_n(ext_select_1_n),
    .oe_n(output_enable_n), .we_n(ext_write_n), .addr(ext_addr), .wdata(ext_wdata),
    .rdata(ext_rdata));
  initial begin
    forever #5 pclk = ~pclk;
  end
  task give_verdict;
    if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // apb transfer; nw counts wait cycles, the answer is taken at the ready edge
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
    nw = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && nw < 200) begin
      nw++;
      @(posedge pclk);
    end
    if (nw >= 200) err_total++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic period(input bit sd, output int n);
    repeat (2) begin
      n = 0;
      do begin
        @(negedge pclk);
        n++;
      end while ((sd ? sdram_autorefresh_req : dram_refresh_req) !== 1'b1 && n < 3000);
    end
  endtask
  initial begin
    #300us;
    err_total++;
    give_verdict;
  end
  initial begin
    int n;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    xfer(0, 16'h8080, 0);
    chk(rd, 32'h1);
    @(negedge pclk);
    chk(bank_access_en, 1'b0);
    xfer(1, 16'h8080, 32'h1);
    @(negedge pclk);
    chk(bank_access_en, 1'b1);
    @(posedge pclk);
    sys_mgr_access <= 1'b1;
    @(posedge pclk);
    sys_mgr_access <= 1'b0;
    @(negedge pclk);
    chk(bank_access_en, 1'b0);
    xfer(0, 16'h8084, 0);
    chk(er, 1'b1);
    chk(rd, 32'h00000000);
    xfer(0, 16'h80b0, 0);
    chk(er, 1'b1);
    for (int i = 0; i < 3; i++) begin
      xfer(1, 16'h80d0, cfg[i]);
      xfer(0, 16'h80d0, 0);
      chk(rd, cfg[i]);
      xfer(1, 16'h81b0, 32'h5a3c + i);
      chk(nw, wt[i]);
      chk(u_dev.mem[12'h06c], mv[i]);
      chk(u_dev.wsel, 2'b01);
      xfer(0, 16'h81b0, 0);
      chk(rd, rv[i]);
    end
    chk(u_dev.mem[12'h06d][7:0], 8'h5a);
    @(posedge pclk);
    port3_bit7_gpio <= 1'b1;
    @(negedge pclk);
    chk(ext_select_1_oe, 1'b0);
    xfer(1, 16'hbfb8, 32'h0777);
    chk(u_dev.wsel, 2'b01);
    port3_bit7_gpio <= 1'b0;
    xfer(1, 16'h80d0, 32'ha06);
    xfer(1, 16'hbfb8, 32'h1234);
    chk(u_dev.wsel, 2'b10);
    xfer(0, 16'hbfb8, 0);
    chk(rd, 32'h1234);
    bank6_memory_type <= MEMTYPE_DRAM;
    xfer(1, 16'h8080, 32'h19fe1);
    @(negedge pclk);
    chk(cas_hold_clks, 3'h5);
    chk(cas_setup_clks, 2'h2);
    period(0, n);
    chk(n, 17);
    @(posedge pclk);
    bank6_memory_type <= 2'h0;
    bank7_memory_type <= MEMTYPE_SDRAM;
    period(1, n);
    chk(n, 17);
    give_verdict;
  end
endmodule
bind erc_ctrl erc_ctrl_monitor u_mon (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
  .pwdata, .pready, .pslverr, .sys_mgr_access, .port2_bit7_gpio, .port3_bit7_gpio,
  .ext_select_0_n, .ext_select_0_oe, .ext_select_1_n, .ext_select_1_oe, .output_enable_n,
  .ext_write_n, .ext_data_oe, .bank_access_en, .dram_refresh_req, .cas_hold_clks,
  .cas_setup_clks);
